//--- tbt_ctrl.sv
`timescale 1ns/100ps
`include "tbt_regs.svh"
module tbt_ctrl #(
  parameter int unsigned LP_PERIOD_CYC = `TBT_LP_PERIOD_CYC,
  parameter int unsigned LINK_LOSS_CYC = `TBT_LINK_LOSS_CYC,
  parameter int unsigned JAB_CYC = `TBT_JAB_CYC,
  parameter int unsigned UNJAB_CYC = `TBT_UNJAB_CYC,
  parameter int FIFO_DEPTH = `TBT_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tx_clk,
  input wire logic tx_en,
  input wire logic txd,
  input wire tbt_pkg::tbt_rx_pins_t tp_rx,
  input wire logic full_duplex,
  input wire logic mode_10t,
  input wire logic force_link_10,
  output logic crs_ff,
  output logic col_ff,
  output logic rx_clk_ff,
  output logic rxd_ff,
  output logic tp_tx_ff,
  output logic tp_oe_ff,
  output logic tp_pre_ff,
  output logic tx_ready_ff,
  output tbt_pkg::tbt_status_t slow_twisted_pair_status_control
);
  localparam int CW = $clog2(FIFO_DEPTH+2);

  // Saturating count of one stretch of time
  function automatic tbt_pkg::tbt_cnt_t inc(input tbt_pkg::tbt_cnt_t c);
    inc = (c == '1) ? c : tbt_pkg::tbt_cnt_t'(c + 1'b1);
  endfunction

  // Synchronisers: three stages on each pin, first stage read by the second only
  logic [2:0] s_txclk_ff, s_txen_ff, s_txd_ff;
  logic [2:0] s_qual_ff, s_lvl_ff, s_dat_ff, s_lp_ff, s_neg_ff;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_txclk_ff <= '0;
      s_txen_ff <= '0;
      s_txd_ff <= '0;
      s_qual_ff <= '0;
      s_lvl_ff <= '0;
      s_dat_ff <= '0;
      s_lp_ff <= '0;
      s_neg_ff <= '0;
    end
    else
    begin
      s_txclk_ff <= {s_txclk_ff[1:0], tx_clk};
      s_txen_ff <= {s_txen_ff[1:0], tx_en};
      s_txd_ff <= {s_txd_ff[1:0], txd};
      s_qual_ff <= {s_qual_ff[1:0], tp_rx.sq_qual};
      s_lvl_ff <= {s_lvl_ff[1:0], tp_rx.sq_level};
      s_dat_ff <= {s_dat_ff[1:0], tp_rx.data};
      s_lp_ff <= {s_lp_ff[1:0], tp_rx.lp};
      s_neg_ff <= {s_neg_ff[1:0], tp_rx.lp_neg};
    end
  end

  // Named views of the synchronised pins
  wire logic txen_s = s_txen_ff[1];
  wire logic txclk_rise = s_txclk_ff[1] & ~s_txclk_ff[2];
  wire logic lp_rise = s_lp_ff[1] & ~s_lp_ff[2];
  wire logic lp_inv = s_neg_ff[1];

  // Link integrity and polarity state
  tbt_pkg::tbt_cnt_t loss_ff;
  logic link_good_ff;
  logic [1:0] inv_cnt_ff;
  logic pol_bad_ff;
  wire logic link_ok = link_good_ff | force_link_10;
  // Data after polarity correction
  wire logic rx_lvl = s_dat_ff[1] ^ pol_bad_ff;
  wire logic rx_lvl_q = s_dat_ff[2] ^ pol_bad_ff;

  // Squelch data-valid window and Manchester receive decoder
  tbt_pkg::tbt_sc_t sq_gap_ff;
  logic sq_valid_ff;
  tbt_pkg::tbt_sc_t since_mid_ff;
  logic rx_act_ff;
  tbt_pkg::tbt_sc_t tail_ff;
  tbt_pkg::tbt_sc_t rxclk_cnt_ff;
  wire logic rx_trans = rx_lvl != rx_lvl_q;
  wire logic rx_en = sq_valid_ff & link_ok;
  wire logic mid_edge = rx_en & rx_trans &
    (since_mid_ff >= tbt_pkg::tbt_sc_t'(`TBT_MID_MIN_CYC));
  wire logic rx_eof = rx_act_ff &
    (since_mid_ff >= tbt_pkg::tbt_sc_t'(`TBT_EOF_CYC));
  wire logic nxt_rx_act = rx_en & (mid_edge | (rx_act_ff & ~rx_eof));
  wire logic rxclk_run = rx_act_ff | (tail_ff != '0);
  wire logic rxclk_half = rxclk_cnt_ff == tbt_pkg::tbt_sc_t'(`TBT_HALF_CYC - 1);

  // Squelch holds valid until the level is missing for the hold time
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sq_gap_ff <= '0;
      sq_valid_ff <= 1'b0;
    end
    else
    begin
      sq_gap_ff <= s_lvl_ff[1] ? '0 : tbt_pkg::tbt_sc_t'(sq_gap_ff + 1'b1);
      if (s_qual_ff[1])
        sq_valid_ff <= 1'b1;
      else if (sq_gap_ff >= tbt_pkg::tbt_sc_t'(`TBT_SQ_HOLD_CYC))
        sq_valid_ff <= 1'b0;
    end
  end

  // Decoder: a transition well past the last mid-bit edge is itself mid-bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_mid_ff <= '1;
      rx_act_ff <= 1'b0;
      rxd_ff <= 1'b0;
    end
    else
    begin
      if (mid_edge)
        since_mid_ff <= '0;
      else if (since_mid_ff != '1)
        since_mid_ff <= tbt_pkg::tbt_sc_t'(since_mid_ff + 1'b1);
      rx_act_ff <= nxt_rx_act;
      if (mid_edge)
        rxd_ff <= rx_lvl; // Level after the mid-bit edge is the bit value
    end
  end

  // Receive clock runs during a frame and for a tail after it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tail_ff <= '0;
      rxclk_cnt_ff <= '0;
      rx_clk_ff <= 1'b0;
    end
    else
    begin
      if (rx_act_ff & ~nxt_rx_act)
        tail_ff <= tbt_pkg::tbt_sc_t'(`TBT_RXCLK_TAIL_CYC);
      else if (tail_ff != '0)
        tail_ff <= tbt_pkg::tbt_sc_t'(tail_ff - 1'b1);
      if (!rxclk_run | rxclk_half)
        rxclk_cnt_ff <= '0;
      else
        rxclk_cnt_ff <= tbt_pkg::tbt_sc_t'(rxclk_cnt_ff + 1'b1);
      if (!rxclk_run)
        rx_clk_ff <= 1'b0;
      else if (rxclk_half)
        rx_clk_ff <= ~rx_clk_ff;
    end
  end

  // Link pulses prove the link, received data only holds off loss; polarity from pulses
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loss_ff <= '0;
      link_good_ff <= 1'b0;
      inv_cnt_ff <= '0;
      pol_bad_ff <= 1'b0;
    end
    else
    begin
      if (lp_rise | rx_act_ff)
        loss_ff <= '0;
      else
        loss_ff <= inc(loss_ff);
      if (lp_rise)
        link_good_ff <= 1'b1;
      else if (loss_ff == tbt_pkg::tbt_cnt_t'(LINK_LOSS_CYC - 1))
        link_good_ff <= 1'b0;
      if (lp_rise)
        inv_cnt_ff <= lp_inv ? 2'(inv_cnt_ff + (inv_cnt_ff != 2'h3)) : '0;
      // Latched until reset; the live condition is not followed
      if (lp_rise & lp_inv & (inv_cnt_ff == 2'(`TBT_POL_BAD_CNT - 1)))
        pol_bad_ff <= 1'b1;
    end
  end

  // Transmit buffer: bits taken on transmit clock rising edges
  logic txq_valid;
  logic txq_ready;
  logic txq_bit;
  logic [CW-1:0] txq_level;
  logic txq_pop;
  wire logic txq_push = txclk_rise & txen_s;

  tbt_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_data(s_txd_ff[1]),
    .wr_valid(txq_push),
    .wr_ready(txq_ready),
    .rd_data(txq_bit),
    .rd_valid(txq_valid),
    .rd_ready(txq_pop),
    .level(txq_level)
  );

  // Encoder state and jabber state
  tbt_pkg::tbt_tx_state_t st_ff;
  tbt_pkg::tbt_tx_state_t nxt_st;
  tbt_pkg::tbt_sc_t cell_ff;
  logic bit_ff;
  tbt_pkg::tbt_cnt_t jab_cnt_ff;
  tbt_pkg::tbt_cnt_t unjab_cnt_ff;
  logic jab_ff;
  tbt_pkg::tbt_cnt_t lp_tmr_ff;
  tbt_pkg::tbt_sc_t lp_cnt_ff;

  wire logic tx_busy = st_ff != tbt_pkg::TX_IDLE;
  wire logic cell_end = cell_ff == tbt_pkg::tbt_sc_t'(`TBT_BIT_CYC - 1);
  wire logic half_end = cell_ff == tbt_pkg::tbt_sc_t'(`TBT_HALF_CYC - 1);
  wire logic first_half = cell_ff < tbt_pkg::tbt_sc_t'(`TBT_HALF_CYC);
  wire logic tx_go = txen_s & link_ok & ~jab_ff;
  wire logic fill_ok = (txq_level >= CW'(`TBT_TX_START_FILL)) | ~txen_s;
  wire logic jab_on = mode_10t;
  wire logic jab_trip = jab_on & tx_busy &
    (jab_cnt_ff == tbt_pkg::tbt_cnt_t'(JAB_CYC - 1));
  wire logic lp_due = ~tx_busy & ~txen_s &
    (lp_tmr_ff == tbt_pkg::tbt_cnt_t'(LP_PERIOD_CYC - 1));
  wire logic lp_on = lp_cnt_ff != '0;

  // Pop one bit per cell; idle with enable low drops leftovers of a refused or cut frame
  assign txq_pop = (st_ff == tbt_pkg::TX_WAIT & fill_ok) |
    (st_ff == tbt_pkg::TX_CELL & cell_end) |
    (st_ff == tbt_pkg::TX_IDLE & ~txen_s); // Stale bits must never lead the next frame

  // Next encoder state
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      tbt_pkg::TX_IDLE:
        if (tx_go)
          nxt_st = tbt_pkg::TX_WAIT;
      tbt_pkg::TX_WAIT:
        if (fill_ok)
          nxt_st = txq_valid ? tbt_pkg::TX_CELL : tbt_pkg::TX_IDLE;
      tbt_pkg::TX_CELL:
        if (cell_end & ~txq_valid)
          nxt_st = bit_ff ? tbt_pkg::TX_IDLE : tbt_pkg::TX_TAIL;
      tbt_pkg::TX_TAIL:
        if (half_end)
          nxt_st = tbt_pkg::TX_IDLE;
      default:
        nxt_st = tbt_pkg::TX_IDLE;
    endcase
    if (jab_trip | ~link_ok)
      nxt_st = tbt_pkg::TX_IDLE;
  end

  // Line level: first half inverted bit, second half the bit itself
  wire logic nxt_oe = (st_ff == tbt_pkg::TX_CELL) | (st_ff == tbt_pkg::TX_TAIL) | lp_on;
  wire logic nxt_tx = (st_ff == tbt_pkg::TX_CELL) ? (first_half ^ bit_ff) :
    ((st_ff == tbt_pkg::TX_TAIL) | lp_on);

  // Encoder registers and line outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= tbt_pkg::TX_IDLE;
      cell_ff <= '0;
      bit_ff <= 1'b0;
      tp_tx_ff <= 1'b0;
      tp_oe_ff <= 1'b0;
      tp_pre_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (txq_pop & txq_valid)
        bit_ff <= txq_bit;
      cell_ff <= (cell_end | nxt_st != st_ff) ? '0 : tbt_pkg::tbt_sc_t'(cell_ff + 1'b1);
      tp_tx_ff <= nxt_tx;
      tp_oe_ff <= nxt_oe;
      tp_pre_ff <= nxt_oe & (nxt_tx != tp_tx_ff); // Boost the cycle after each edge
    end
  end

  // Jabber: cut after long activity, release after a long quiet enable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jab_cnt_ff <= '0;
      unjab_cnt_ff <= '0;
      jab_ff <= 1'b0;
    end
    else
    begin
      jab_cnt_ff <= (jab_on & tx_busy) ? inc(jab_cnt_ff) : '0;
      unjab_cnt_ff <= (jab_ff & ~txen_s) ? inc(unjab_cnt_ff) : '0;
      if (!jab_on)
        jab_ff <= 1'b0;
      else if (jab_trip)
        jab_ff <= 1'b1;
      else if (unjab_cnt_ff == tbt_pkg::tbt_cnt_t'(UNJAB_CYC - 1))
        jab_ff <= 1'b0;
    end
  end

  // Link pulse timer runs only while no frame is sent
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lp_tmr_ff <= '0;
      lp_cnt_ff <= '0;
    end
    else
    begin
      lp_tmr_ff <= (tx_busy | txen_s | lp_due) ? '0 : inc(lp_tmr_ff);
      if (lp_due)
        lp_cnt_ff <= tbt_pkg::tbt_sc_t'(`TBT_LP_CYC);
      else if (lp_on)
        lp_cnt_ff <= tbt_pkg::tbt_sc_t'(lp_cnt_ff - 1'b1);
    end
  end

  // Carrier sense, collision and status flags toward the controller
  wire logic nxt_crs = rx_act_ff | (~full_duplex & tx_busy);
  wire logic nxt_col = ~full_duplex & link_ok & ((tx_busy & rx_act_ff) | jab_ff);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crs_ff <= 1'b0;
      col_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      slow_twisted_pair_status_control <= '0;
    end
    else
    begin
      crs_ff <= nxt_crs;
      col_ff <= nxt_col;
      tx_ready_ff <= txq_ready;
      slow_twisted_pair_status_control <= {link_ok, pol_bad_ff, jab_ff};
    end
  end
endmodule

//--- tbt_regs.svh
// Notes on behaviour
// - Receive activity raises carrier sense only after squelch has qualified the data.
// - Half duplex: carrier sense is high while transmitting or receiving.
// - Full duplex: carrier sense follows receive activity only, never own transmission.
// - Receive frame ends once mid-bit transitions stop arriving.
// - Carrier sense falls within one and a half bit times of the last bit.
// - Receive clock keeps toggling five bit times after carrier sense falls.
// - With no transmit data, a 100 ns link pulse goes out every 16 ms.
// - Without valid link pulses, transmit, receive and collision detection are disabled.
// - Forced-good-link makes the link good whatever link pulses do.
// - Jabber timer cuts the transmitter after about 85 ms of continuous activity.
// - After jabber, transmit stays off until enable has been low about 500 ms.
// - Jabber protection acts only in 10 Mb/s twisted-pair mode.
// - Three inverted link pulses in a row report bad polarity.
// - Bad polarity stays latched in the status and control flags.
// - Reversed polarity is corrected by inverting the received signal internally.
// - Rising transmit enable starts Manchester encoding, kept up while enable is high.
// - Transmit data is sampled on each rising edge of the transmit clock.
// - Frame ends with a positive last transition, mid-cell for one, cell end for zero.
// - Squelch keeps data valid until the threshold is unmet for over 150 ns.
`ifndef TBT_REGS_SVH
`define TBT_REGS_SVH

`define TBT_CLK_MHZ 100
`define TBT_CNT_W 27
`define TBT_SC_W 8
// Bit cell and its derived cycle counts
`define TBT_BIT_NS 100
`define TBT_BIT_CYC ((`TBT_BIT_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_HALF_CYC (`TBT_BIT_CYC / 2)
`define TBT_MID_MIN_NS 70
`define TBT_MID_MIN_CYC ((`TBT_MID_MIN_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_EOF_NS 130
`define TBT_EOF_CYC ((`TBT_EOF_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_SQ_HOLD_NS 150
`define TBT_SQ_HOLD_CYC ((`TBT_SQ_HOLD_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_RXCLK_TAIL_BITS 5
`define TBT_RXCLK_TAIL_CYC (`TBT_RXCLK_TAIL_BITS * `TBT_BIT_CYC)
// Link pulse
`define TBT_LP_NS 100
`define TBT_LP_CYC ((`TBT_LP_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_LP_PERIOD_MS 16
`define TBT_LP_PERIOD_CYC (`TBT_LP_PERIOD_MS * 1000 * `TBT_CLK_MHZ)
`define TBT_LINK_LOSS_MS 100
`define TBT_LINK_LOSS_CYC (`TBT_LINK_LOSS_MS * 1000 * `TBT_CLK_MHZ)
`define TBT_POL_BAD_CNT 3
// Jabber
`define TBT_JAB_MS 85
`define TBT_JAB_CYC (`TBT_JAB_MS * 1000 * `TBT_CLK_MHZ)
`define TBT_UNJAB_MS 500
`define TBT_UNJAB_CYC (`TBT_UNJAB_MS * 1000 * `TBT_CLK_MHZ)
// Transmit buffer
`define TBT_FIFO_DEPTH 32
`define TBT_TX_START_FILL 16

`endif

//--- tbt_pkg.sv
`include "tbt_regs.svh"
package tbt_pkg;
  typedef logic [`TBT_CNT_W-1:0] tbt_cnt_t;
  typedef logic [`TBT_SC_W-1:0] tbt_sc_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_CELL, TX_TAIL} tbt_tx_state_t;
  // Receive side comparator outputs from the analogue front end
  typedef struct packed {
    logic sq_qual;
    logic sq_level;
    logic data;
    logic lp;
    logic lp_neg;
  } tbt_rx_pins_t;
  // Flags of the slow twisted pair status and control group
  typedef struct packed {
    logic link_ok;
    logic pol_bad;
    logic jabber;
  } tbt_status_t;
endpackage

//--- tbt_fifo.sv
`timescale 1ns/100ps
module tbt_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [$clog2(DEPTH+2)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+2);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic ov_ff;
  logic [WIDTH-1:0] od_ff;
  wire logic push;
  wire logic take;

  // Full comes from the stored count, so ready never loops back combinationally
  assign wr_ready = cnt_ff < CW'(DEPTH);
  assign push = wr_valid & wr_ready;
  assign take = (cnt_ff != '0) & (~ov_ff | rd_ready);
  assign rd_data = od_ff;
  assign rd_valid = ov_ff;
  assign level = cnt_ff + CW'(ov_ff);

  // Storage array, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_ff] <= wr_data;
  end

  // Pointers, count and registered output stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      ov_ff <= 1'b0;
      od_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= AW'(wp_ff + 1'b1);
      if (take)
      begin
        rp_ff <= AW'(rp_ff + 1'b1);
        od_ff <= mem[rp_ff];
        ov_ff <= 1'b1;
      end
      else if (rd_ready)
        ov_ff <= 1'b0;
      cnt_ff <= CW'(cnt_ff + CW'(push) - CW'(take));
    end
  end
endmodule

//--- tbt_ctrl_asserts.sv
`timescale 1ns/100ps
module tbt_ctrl_asserts #(
  parameter int unsigned LP_PERIOD_CYC = 200,
  parameter int unsigned JAB_CYC = 500
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tx_clk,
  input wire logic tx_en,
  input wire logic txd,
  input wire tbt_pkg::tbt_rx_pins_t tp_rx,
  input wire logic full_duplex,
  input wire logic mode_10t,
  input wire logic force_link_10,
  input wire logic crs_ff,
  input wire logic col_ff,
  input wire logic rx_clk_ff,
  input wire logic rxd_ff,
  input wire logic tp_tx_ff,
  input wire logic tp_oe_ff,
  input wire logic tp_pre_ff,
  input wire logic tx_ready_ff,
  input wire tbt_pkg::tbt_status_t slow_twisted_pair_status_control
);
  logic [15:0] idle_ff;
  logic [15:0] oe_ff;
  logic [15:0] rxq_ff;
  logic [15:0] lpw_ff;
  logic [1:0] neg_ff;
  logic lp_ff;
  logic dat_ff;
  tbt_pkg::tbt_status_t st;
  assign st = slow_twisted_pair_status_control;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Gap and run counters; 16 bits outlast any run of this bench
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_ff <= '0;
      oe_ff <= '0;
      rxq_ff <= '0;
      lpw_ff <= '0;
      neg_ff <= '0;
      lp_ff <= 1'b0;
      dat_ff <= 1'b0;
    end
    else
    begin
      idle_ff <= (tp_oe_ff || tx_en || st.jabber) ? '0 : idle_ff + 16'h1;
      oe_ff <= tp_oe_ff ? oe_ff + 16'h1 : '0;
      // Run of driven high line; stands in for a long repetition
      lpw_ff <= (tp_oe_ff && tp_tx_ff) ? lpw_ff + 16'h1 : '0;
      rxq_ff <= (tp_rx.sq_qual || tp_rx.data != dat_ff) ? '0 : rxq_ff + 16'h1;
      if (tp_rx.lp && !lp_ff)
        neg_ff <= tp_rx.lp_neg ? neg_ff + {1'b0, neg_ff != 2'h3} : 2'h0;
      lp_ff <= tp_rx.lp;
      dat_ff <= tp_rx.data;
    end
  end
  // Margins below allow for the three-stage input synchronisers
  a_fd_crs_rx: assert property (full_duplex && crs_ff |-> rxq_ff < 16'h1E)
    else $error("crs without receive activity");
  a_crs_eop: assert property (crs_ff && idle_ff > 16'h8 |-> rxq_ff <= 16'h12)
    else $error("crs held past end of frame");
  a_rxclk_tail: assert property ($fell(crs_ff) && rxq_ff < 16'h1E |-> ##[41:55] $changed(rx_clk_ff))
    else $error("receive clock tail missing");
  a_lp_period: assert property (idle_ff <= LP_PERIOD_CYC + 32'h10)
    else $error("link pulse overdue");
  a_lp_width: assert property ($rose(tp_oe_ff) && idle_ff > 16'h32 && tx_ready_ff
    |-> ##10 !tp_oe_ff && lpw_ff == 16'hA)
    else $error("link pulse width wrong");
  a_jab_cut: assert property (mode_10t |-> oe_ff <= JAB_CYC + 32'h4)
    else $error("transmitter ran past jabber limit");
  a_unjab_hold: assert property ($past(st.jabber, 2) && st.jabber && tx_en |-> !tp_oe_ff)
    else $error("transmit during jabber");
  a_pol_three: assert property ($rose(st.pol_bad) |-> neg_ff == 2'h3)
    else $error("bad polarity too early");
  a_pol_latch: assert property (!$fell(st.pol_bad))
    else $error("bad polarity not held");
  a_tx_end_pos: assert property ($fell(tp_oe_ff) && $past(tp_oe_ff, 11) && !tx_en
    |-> $past(tp_tx_ff) && !$past(tp_tx_ff, 6))
    else $error("frame end not a rising transition");
  c_crs: cover property ($rose(crs_ff));
  c_jab: cover property ($rose(st.jabber));
  c_pol: cover property ($rose(st.pol_bad));
endmodule
bind tbt_ctrl tbt_ctrl_asserts #(.LP_PERIOD_CYC(LP_PERIOD_CYC), .JAB_CYC(JAB_CYC)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd),
  .tp_rx(tp_rx), .full_duplex(full_duplex), .mode_10t(mode_10t),
  .force_link_10(force_link_10), .crs_ff(crs_ff), .col_ff(col_ff), .rx_clk_ff(rx_clk_ff),
  .rxd_ff(rxd_ff), .tp_tx_ff(tp_tx_ff), .tp_oe_ff(tp_oe_ff), .tp_pre_ff(tp_pre_ff),
  .tx_ready_ff(tx_ready_ff),
  .slow_twisted_pair_status_control(slow_twisted_pair_status_control)
);

//--- tbt_mac_model.sv
`timescale 1ns/100ps
module tbt_mac_model (
  output logic tx_clk = 1'b0,
  output logic tx_en = 1'b0,
  output logic txd = 1'b0
);
  // Bit clock runs only inside a frame; data changes after the falling edge
  task automatic send(input logic [79:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      txd = b[i];
      tx_en = 1'b1;
      #62.5 tx_clk = 1'b1;
      #62.5 tx_clk = 1'b0;
    end
    // Released data shows the opposite of its last value
    txd = ~txd;
    tx_en = 1'b0;
  endtask
endmodule

//--- test_tenbase_t_transceiver_control.sv
`timescale 1ns/100ps
module test_tenbase_t_transceiver_control;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic tx_clk, tx_en, txd;
  tbt_pkg::tbt_rx_pins_t tp_rx = '0;
  logic full_duplex = 1'b0;
  logic mode_10t = 1'b1;
  logic force_link_10 = 1'b0;
  logic crs_ff, col_ff, rx_clk_ff, rxd_ff, tp_tx_ff, tp_oe_ff, tp_pre_ff, tx_ready_ff;
  tbt_pkg::tbt_status_t slow_twisted_pair_status_control;
  tbt_pkg::tbt_status_t st;
  logic lp_on = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  assign st = slow_twisted_pair_status_control;
  // Short counts keep the run small
  tbt_ctrl #(.LP_PERIOD_CYC(200), .LINK_LOSS_CYC(1000), .JAB_CYC(500),
    .UNJAB_CYC(300)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd),
    .tp_rx(tp_rx), .full_duplex(full_duplex), .mode_10t(mode_10t),
    .force_link_10(force_link_10), .crs_ff(crs_ff), .col_ff(col_ff), .rx_clk_ff(rx_clk_ff),
    .rxd_ff(rxd_ff), .tp_tx_ff(tp_tx_ff), .tp_oe_ff(tp_oe_ff), .tp_pre_ff(tp_pre_ff),
    .tx_ready_ff(tx_ready_ff),
    .slow_twisted_pair_status_control(slow_twisted_pair_status_control)
  );
  tbt_mac_model i_mac (.tx_clk(tx_clk), .tx_en(tx_en), .txd(txd));
  always #5 clk_sys = ~clk_sys;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic lpulse(input logic neg);
    tp_rx.lp_neg = neg;
    tp_rx.lp = 1'b1;
    cyc(10);
    tp_rx.lp = 1'b0;
    cyc(30);
  endtask
  // Partner pulses keep the link alive; off while polarity is probed
  always
  begin
    cyc(300);
    if (lp_on)
      lpulse(1'b0);
  end
  // Manchester frame, first half inverted; last bit is a one
  task automatic rx_frame(input logic [31:0] b, input logic inv, input logic exp_crs);
    tp_rx.data = inv;
    cyc(4);
    tp_rx.sq_qual = 1'b1;
    tp_rx.sq_level = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      tp_rx.data = ~b[i] ^ inv;
      cyc(5);
      tp_rx.data = b[i] ^ inv;
      cyc(5);
      if (i == 4)
        check("crs_rx", crs_ff, exp_crs);
    end
    check("rxd_last", rxd_ff, exp_crs);
    tp_rx.sq_qual = 1'b0;
    tp_rx.sq_level = 1'b0;
    tp_rx.data = 1'b0;
    cyc(20);
    check("crs_eop", crs_ff, 1'b0);
  endtask
  task automatic tx_frame(input logic [79:0] b, input int n, input logic exp_crs);
    int k;
    fork
      i_mac.send(b, n);
      begin
        cyc(20);
        for (k = 0; k < 400 && tp_oe_ff !== 1'b1; k++)
          cyc(1);
        check("crs_tx", crs_ff, exp_crs);
        check("col_tx", col_ff, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
          cyc(2);
          check("cell_first", tp_tx_ff, !b[i]);
          check("pre_flat", tp_pre_ff, 1'b0);
          cyc(5);
          check("cell_second", tp_tx_ff, b[i]);
          cyc(3);
        end
      end
    join
    for (k = 0; k < 300 && tp_oe_ff !== 1'b0; k++)
      cyc(1);
    check("tx_done", tp_oe_ff, 1'b0);
  endtask
  task automatic t_link();
    check("link_down", st.link_ok, 1'b0);
    rx_frame(32'hB555_5555, 1'b0, 1'b0);
    i_mac.send(80'h3_FFFF_FFFF, 34);
    cyc(2);
    check("buf_full", tx_ready_ff, 1'b0);
    check("tx_refused", tp_oe_ff, 1'b0);
    force_link_10 = 1'b1;
    rx_frame(32'hB555_5555, 1'b0, 1'b1);
    cyc(400);
    check("buf_drained", tx_ready_ff, 1'b1);
    force_link_10 = 1'b0;
    lp_on = 1'b1;
    cyc(350);
    check("link_up", st.link_ok, 1'b1);
    $display("test link done");
  endtask
  task automatic t_rx();
    rx_frame(32'hB555_5555, 1'b0, 1'b1);
    $display("test receive done");
  endtask
  // Half duplex counts own transmission as carrier, full duplex does not
  task automatic t_tx();
    tx_frame(80'h3C_C5A3, 24, 1'b1);
    full_duplex = 1'b1;
    tx_frame(80'hFF_5A69, 24, 1'b0);
    full_duplex = 1'b0;
    $display("test transmit done");
  endtask
  task automatic t_lp();
    int k;
    for (k = 0; k < 260 && tp_oe_ff !== 1'b1; k++)
      cyc(1);
    for (k = 0; tp_oe_ff === 1'b1 && k < 20; k++)
      cyc(1);
    check("lp_width", k, 10);
    $display("test link pulse done");
  endtask
  task automatic t_pol();
    lp_on = 1'b0;
    cyc(41);
    lpulse(1'b1);
    lpulse(1'b1);
    check("pol_two", st.pol_bad, 1'b0);
    lpulse(1'b1);
    check("pol_three", st.pol_bad, 1'b1);
    lp_on = 1'b1;
    cyc(350);
    check("pol_held", st.pol_bad, 1'b1);
    rx_frame(32'hB555_5555, 1'b1, 1'b1);
    $display("test polarity done");
  endtask
  task automatic t_jab();
    i_mac.send({10{8'hA5}}, 70);
    cyc(2);
    check("jab_set", st.jabber, 1'b1);
    check("jab_col", col_ff, 1'b1);
    cyc(150);
    check("jab_hold", st.jabber, 1'b1);
    cyc(200);
    check("jab_clear", st.jabber, 1'b0);
    mode_10t = 1'b0;
    i_mac.send({10{8'hA5}}, 70);
    cyc(200);
    check("jab_off", st.jabber, 1'b0);
    mode_10t = 1'b1;
    $display("test jabber done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole sequence needs under 10000 cycles
  initial
  begin
    #300000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    t_link();
    t_rx();
    t_tx();
    t_lp();
    t_pol();
    t_jab();
    print_verdict();
  end
endmodule
